/* rtl/buck_fault_sequencer.sv */
`timescale 1ns/100ps
module buck_fault_sequencer #(
  parameter int unsigned PHASES  = 2,
  parameter int unsigned SLEW_W  = 16
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  input  wire logic                enable,
  input  wire logic [4:0]          voltage_code,
  input  wire logic                filtered_bias_supply_ok,
  input  wire logic                slew_set_pin,
  input  wire logic [11:0]         output_feedback,
  input  wire logic [11:0]         thermistor_sense,
  input  wire logic [7:0]          die_temp,
  input  wire logic [PHASES-1:0]   on_pulse_req,
  input  wire logic [PHASES-1:0]   over_current,
  input  wire logic [PHASES-1:0]   sink_over_current,
  input  wire logic [PHASES-1:0]   switch_node_sense,
  input  wire logic [PHASES-1:0]   low_side_sense,
  output logic [PHASES-1:0]        high_side_gate_drive,
  output logic [PHASES-1:0]        low_side_gate_drive,
  output logic [11:0]              dac_target_voltage,
  output logic                     feedback_discharge,
  input  wire logic                power_good_in,
  output logic                     power_good_out,
  output logic                     power_good_oe,
  input  wire logic                thermal_alert_in,
  output logic                     thermal_alert_out,
  output logic                     thermal_alert_oe
);

  // Parameters the logic cannot serve are refused.
  if (PHASES < 1 || PHASES > 8 || SLEW_W < 5 || SLEW_W > 24)
  begin : g_bad_param
    $error("buck_fault_sequencer: unsupported parameter value");
  end

  buck_seq_pkg::seq_state_t state_r;
  buck_seq_pkg::seq_state_t state_nxt;
  logic [11:0]           dac_r;
  logic [11:0]           code_mv;
  logic [11:0]           goal_mv;
  logic                  ramping;
  logic [SLEW_W-1:0]     slew_period_r;
  logic [SLEW_W+5:0]     slew_acc_r;
  logic [SLEW_W+5:0]     slew_sum;
  logic [SLEW_W+5:0]     slew_thr;
  logic                  slew_tick;
  logic                  ovp_enabled;
  logic                  above_upper;
  logic                  below_lower;
  logic                  ovp_trip;
  logic                  fixed_trip;
  logic                  hot_r;
  logic                  uv_trip;
  logic [11:0]           uv_cnt_r;
  logic                  stop_fault_r;
  logic [3:0]            fault_r;
  logic                  pg_r;
  logic                  alert_r;
  logic                  drive_ok;
  logic [PHASES-1:0]     hs_r;
  logic [PHASES-1:0]     ls_r;
  logic                  dis_r;
  logic                  rd_hit;
  logic [31:0]           rd_mux;

  // Code decode: all ones has its own level, enable low gives zero.
  always_comb
  begin
    if (!enable)
      code_mv = 12'h000;
    else if (voltage_code == buck_seq_pkg::CODE_ALL_ONES)
      code_mv = buck_seq_pkg::CODE_ONES_MV;
    else
      code_mv = buck_seq_pkg::CODE_TOP_MV - buck_seq_pkg::CODE_STEP_MV * {7'h00, voltage_code};
  end

  // Ramp goal follows the code in run and the stop level in soft stop.
  always_comb
  begin
    if (state_r == buck_seq_pkg::ST_RUN)
      goal_mv = code_mv;
    else if (state_r == buck_seq_pkg::ST_STOP)
      goal_mv = (dac_r > buck_seq_pkg::STOP_MV) ? buck_seq_pkg::STOP_MV : dac_r;
    else
      goal_mv = 12'h000;
  end

  assign ramping = (state_r == buck_seq_pkg::ST_RUN || state_r == buck_seq_pkg::ST_STOP)
                   && (dac_r != goal_mv);

  // Grounded slew pin keeps the trip; the reference setting slows the rate.
  assign ovp_enabled = !slew_set_pin;
  assign slew_sum = slew_acc_r + {{(SLEW_W+1){1'b0}},
                    (slew_set_pin ? buck_seq_pkg::SLEW_INC_REF : buck_seq_pkg::SLEW_INC_GND)};
  // Threshold is formed at full accumulator width so long periods never wrap.
  assign slew_thr = (SLEW_W+6)'(slew_period_r == '0 ? SLEW_W'(1) : slew_period_r)
                    * (SLEW_W+6)'(buck_seq_pkg::SLEW_INC_GND);
  assign slew_tick = ramping && (slew_sum >= slew_thr);

  // Slew rate accumulator; the rate never depends on load or frequency.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slew_acc_r <= '0;
    else if (!ramping)
      slew_acc_r <= '0;
    else if (slew_tick)
      slew_acc_r <= slew_sum - slew_thr;
    else
      slew_acc_r <= slew_sum;
  end

  // Target moves one millivolt per tick toward its goal.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dac_r <= 12'h000;
    else if (state_r != buck_seq_pkg::ST_RUN && state_r != buck_seq_pkg::ST_STOP)
      dac_r <= 12'h000;
    else if (slew_tick && dac_r < goal_mv)
      dac_r <= dac_r + 12'h001;
    else if (slew_tick && dac_r > goal_mv)
      dac_r <= dac_r - 12'h001;
  end

  // Window comparisons in 13 bits so the limits never wrap.
  assign above_upper = {1'b0, output_feedback} > {1'b0, dac_r} + {1'b0, buck_seq_pkg::PG_HIGH_MV};
  assign below_lower = {1'b0, output_feedback} + {1'b0, buck_seq_pkg::PG_LOW_MV} < {1'b0, dac_r};
  assign ovp_trip    = ovp_enabled && !ramping && state_r == buck_seq_pkg::ST_RUN
                       && ({1'b0, output_feedback} > {1'b0, dac_r} + {1'b0, buck_seq_pkg::OVP_MV});
  assign fixed_trip  = output_feedback > buck_seq_pkg::FIXED_OVP_MV;
  assign uv_trip     = below_lower && !ramping && state_r == buck_seq_pkg::ST_RUN
                       && uv_cnt_r == 12'(buck_seq_pkg::UV_CYCLES - 1);

  // Undervoltage persistence counter, restarted by any cycle inside limits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uv_cnt_r <= 12'h000;
    else if (!below_lower || ramping || state_r != buck_seq_pkg::ST_RUN)
      uv_cnt_r <= 12'h000;
    else if (uv_cnt_r != 12'(buck_seq_pkg::UV_CYCLES - 1))
      uv_cnt_r <= uv_cnt_r + 12'h001;
  end

  // Thermal shutdown level with cooling hysteresis.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hot_r <= 1'b0;
    else if (die_temp >= buck_seq_pkg::SHUTDOWN_C)
      hot_r <= 1'b1;
    else if (die_temp <= buck_seq_pkg::COOL_C)
      hot_r <= 1'b0;
  end

  // Sequencer next state.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      buck_seq_pkg::ST_OFF:
        if (enable && !hot_r)
          state_nxt = buck_seq_pkg::ST_RUN;
      buck_seq_pkg::ST_RUN:
        if (die_temp >= buck_seq_pkg::SHUTDOWN_C)
          state_nxt = buck_seq_pkg::ST_LATCH;
        else if (!enable || ovp_trip || uv_trip)
          state_nxt = buck_seq_pkg::ST_STOP;
      buck_seq_pkg::ST_STOP:
        if (die_temp >= buck_seq_pkg::SHUTDOWN_C)
          state_nxt = buck_seq_pkg::ST_LATCH;
        else if (dac_r <= buck_seq_pkg::STOP_MV)
          state_nxt = stop_fault_r ? buck_seq_pkg::ST_LATCH : buck_seq_pkg::ST_OFF;
      buck_seq_pkg::ST_LATCH:
        if (!enable && !hot_r)
          state_nxt = buck_seq_pkg::ST_OFF;
      buck_seq_pkg::ST_CROWBAR:
        if (!enable)
          state_nxt = buck_seq_pkg::ST_OFF;
      default:
        state_nxt = buck_seq_pkg::ST_OFF;
    endcase
    if (fixed_trip)
      state_nxt = buck_seq_pkg::ST_CROWBAR;
  end

  // Bias supply loss returns everything to off without latching.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= buck_seq_pkg::ST_OFF;
    else if (!filtered_bias_supply_ok)
      state_r <= buck_seq_pkg::ST_OFF;
    else
      state_r <= state_nxt;
  end

  // Fault causes; cleared only by a bias restart or a next state of off, unless coming from soft stop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_r      <= 4'h0;
      stop_fault_r <= 1'b0;
    end
    else if (!filtered_bias_supply_ok)
    begin
      fault_r      <= 4'h0;
      stop_fault_r <= 1'b0;
    end
    else
    begin
      if (state_nxt == buck_seq_pkg::ST_OFF && state_r != buck_seq_pkg::ST_STOP)
        fault_r <= 4'h0;
      if (ovp_trip)
        fault_r[buck_seq_pkg::FLT_OVP] <= 1'b1;
      if (uv_trip)
        fault_r[buck_seq_pkg::FLT_UVP] <= 1'b1;
      if (fixed_trip)
        fault_r[buck_seq_pkg::FLT_FIXED] <= 1'b1;
      if (die_temp >= buck_seq_pkg::SHUTDOWN_C)
        fault_r[buck_seq_pkg::FLT_THERM] <= 1'b1;
      if (state_r == buck_seq_pkg::ST_RUN)
        stop_fault_r <= ovp_trip || uv_trip;
    end
  end

  // Power good: forced low off-run, windowed when settled, held while ramping unless above the upper limit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pg_r <= 1'b0;
    else if (!enable || state_r != buck_seq_pkg::ST_RUN || state_nxt != buck_seq_pkg::ST_RUN)
      pg_r <= 1'b0;
    else if (above_upper || (below_lower && !ramping))
      pg_r <= 1'b0;
    else if (!ramping)
      pg_r <= 1'b1;
  end

  // Thermal alert follows the sense level; regulation is untouched.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alert_r <= 1'b0;
    else
      alert_r <= thermistor_sense >= buck_seq_pkg::ALERT_MV;
  end

  // Per-phase gate drive with valley limits and cross-conduction interlock.
  assign drive_ok = state_r == buck_seq_pkg::ST_RUN || state_r == buck_seq_pkg::ST_STOP;

  for (genvar i = 0; i < PHASES; i++)
  begin : g_phase
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        hs_r[i] <= 1'b0;
        ls_r[i] <= 1'b0;
      end
      else if (state_r == buck_seq_pkg::ST_CROWBAR)
      begin
        hs_r[i] <= 1'b0;
        ls_r[i] <= 1'b1;
      end
      else
      begin
        hs_r[i] <= drive_ok && on_pulse_req[i] && !over_current[i]
                   && !low_side_sense[i] && !ls_r[i];
        ls_r[i] <= drive_ok && !on_pulse_req[i] && !sink_over_current[i]
                   && !switch_node_sense[i] && !hs_r[i];
      end
    end
  end

  // Discharge path after the stop completes and while held off.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dis_r <= 1'b1;
    else
      dis_r <= state_r == buck_seq_pkg::ST_OFF || state_r == buck_seq_pkg::ST_LATCH;
  end

  assign high_side_gate_drive = hs_r;
  assign low_side_gate_drive  = ls_r;
  assign dac_target_voltage   = dac_r;
  assign feedback_discharge   = dis_r;
  assign power_good_out       = 1'b0;
  assign power_good_oe        = !pg_r;
  assign thermal_alert_out    = 1'b0;
  assign thermal_alert_oe     = alert_r;

  // Register slave: zero wait states, read data captured in the setup cycle.
  assign rd_hit  = paddr == buck_seq_pkg::CTRL_OFS || paddr == buck_seq_pkg::STATUS_OFS
                   || paddr == buck_seq_pkg::TARGET_OFS || paddr == buck_seq_pkg::FAULT_OFS;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      buck_seq_pkg::CTRL_OFS:   rd_mux[SLEW_W-1:0] = slew_period_r;
      buck_seq_pkg::STATUS_OFS:
      begin
        rd_mux[buck_seq_pkg::ST_STATE_LSB +: 5] = state_r;
        rd_mux[buck_seq_pkg::ST_RAMP_BIT]  = ramping;
        rd_mux[buck_seq_pkg::ST_PG_BIT]    = pg_r;
        rd_mux[buck_seq_pkg::ST_ALERT_BIT] = alert_r;
        rd_mux[buck_seq_pkg::ST_OVPEN_BIT] = ovp_enabled;
        rd_mux[buck_seq_pkg::ST_DISCH_BIT] = dis_r;
        rd_mux[buck_seq_pkg::ST_PGPIN_BIT] = power_good_in;
        rd_mux[buck_seq_pkg::ST_ALPIN_BIT] = thermal_alert_in;
      end
      buck_seq_pkg::TARGET_OFS: rd_mux[11:0] = dac_r;
      buck_seq_pkg::FAULT_OFS:  rd_mux[3:0]  = fault_r;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // Slew period register steers the ramp rate.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slew_period_r <= SLEW_W'(buck_seq_pkg::SLEW_PERIOD_RST);
    else if (psel && penable && pwrite && paddr == buck_seq_pkg::CTRL_OFS)
      slew_period_r <= pwdata[SLEW_W-1:0];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CODE_TARGET: assert property (
    enable && voltage_code == 5'h1F |-> code_mv == 12'h190)
    else $error("code all ones did not give 400 mV");
  AST_RAMP_STEP: assert property (
    $changed(dac_r) && $past(state_r) == buck_seq_pkg::ST_RUN && state_r == buck_seq_pkg::ST_RUN
    |-> (dac_r == $past(dac_r) + 12'h001) || (dac_r == $past(dac_r) - 12'h001))
    else $error("target moved by more than one step");
  AST_OVP_TRIP: assert property (
    ovp_trip && filtered_bias_supply_ok && !fixed_trip && die_temp < 8'hA0
    |=> state_r == buck_seq_pkg::ST_STOP && fault_r[0] && !pg_r)
    else $error("overvoltage trip did not start soft stop");
  AST_NO_OVP_REF: assert property (
    slew_set_pin |-> !ovp_trip)
    else $error("overvoltage trip while disabled");
  AST_STOP_END: assert property (
    state_r == buck_seq_pkg::ST_STOP && dac_r <= 12'h12C && filtered_bias_supply_ok
    && !fixed_trip && die_temp < 8'hA0
    |=> (state_r == buck_seq_pkg::ST_OFF || state_r == buck_seq_pkg::ST_LATCH)
    ##1 feedback_discharge && hs_r == '0 && ls_r == '0)
    else $error("soft stop end did not park the gates");
  AST_UVLO: assert property (
    !filtered_bias_supply_ok |=> state_r == buck_seq_pkg::ST_OFF && fault_r == 4'h0)
    else $error("bias loss did not reset sequencer");
  AST_PG_ENABLE: assert property (
    !enable |=> power_good_oe)
    else $error("power good stayed active with enable low");
  AST_PG_UPPER: assert property (
    above_upper |=> !pg_r)
    else $error("power good active above upper limit");
  AST_UV_TIME: assert property (
    uv_trip && filtered_bias_supply_ok && !fixed_trip && die_temp < 8'hA0
    |=> state_r == buck_seq_pkg::ST_STOP ##1 stop_fault_r)
    else $error("undervoltage timeout did not stop");
  AST_FIXED_OVP: assert property (
    fixed_trip && filtered_bias_supply_ok |=> state_r == buck_seq_pkg::ST_CROWBAR
    ##1 ls_r == {PHASES{1'b1}} && power_good_oe)
    else $error("fixed overvoltage did not force low-side on");
  AST_VALLEY: assert property (
    over_current != '0 |=> (hs_r & $past(over_current)) == '0)
    else $error("on-pulse given over current limit");
  AST_INTERLOCK: assert property (
    (hs_r & ls_r) == '0)
    else $error("both switches of a phase driven");
  AST_ALERT: assert property (
    thermistor_sense >= 12'h2D0 |=> thermal_alert_oe)
    else $error("thermal alert not raised");
  AST_THERMAL: assert property (
    die_temp >= 8'hA0 && state_r == buck_seq_pkg::ST_RUN && filtered_bias_supply_ok
    && !fixed_trip |=> state_r == buck_seq_pkg::ST_LATCH)
    else $error("thermal shutdown missed");

  COV_START: cover property (state_r == buck_seq_pkg::ST_OFF ##1 state_r == buck_seq_pkg::ST_RUN);
  COV_PG_UP: cover property (!pg_r ##1 pg_r);
  COV_UV_LATCH: cover property (uv_trip ##[1:1000] state_r == buck_seq_pkg::ST_LATCH);
  COV_CROWBAR: cover property (state_r == buck_seq_pkg::ST_CROWBAR);

endmodule : buck_fault_sequencer

/* shared/buck_seq_pkg.sv */
// Functional notes
// - Five-bit code sets target; enable low gives zero.
// - Target ramps stepwise at one common rate.
// - Grounded slew pin keeps overvoltage trip; reference slows.
// - Start ramps target from zero to code.
// - Enable low ramps target down to 300 mV.
// - Stop end: gates low, feedback discharge on.
// - Bias supply loss resets everything, never latches.
// - Power good only inside target window.
// - Power good drops on enable low or undervoltage.
// - Window evaluation held while target ramps.
// - Above upper limit always drops power good.
// - Overvoltage trip: drop good, soft stop, latch.
// - Latched off until bias or enable cycled.
// - Fixed 1.7 V trip forces low-side gates high.
// - Undervoltage for 80 us: soft stop, latch.
// - Valley limit withholds next on-pulse per phase.
// - Overcurrent ends through undervoltage shut-off.
// - Sinking limit 50% above positive, valley style.
// - Thermal alert low at 720 mV sense.
// - 160 C shutdown; restart cooled and recycled.
// - Gate drive confirms one switch off first; crowbar forces low-side on with no check.
package buck_seq_pkg;

  // Millivolt quantities share one width.
  localparam int unsigned MV_W           = 12;
  localparam logic [11:0] CODE_TOP_MV    = 12'h4E2;
  localparam logic [11:0] CODE_STEP_MV   = 12'h019;
  localparam logic [4:0]  CODE_ALL_ONES  = 5'h1F;
  localparam logic [11:0] CODE_ONES_MV   = 12'h190;
  localparam logic [11:0] STOP_MV        = 12'h12C;
  localparam logic [11:0] PG_HIGH_MV     = 12'h0C8;
  localparam logic [11:0] PG_LOW_MV      = 12'h12C;
  localparam logic [11:0] OVP_MV         = 12'h0C8;
  localparam logic [11:0] FIXED_OVP_MV   = 12'h6A4;
  localparam logic [11:0] ALERT_MV       = 12'h2D0;
  localparam logic [7:0]  SHUTDOWN_C     = 8'hA0;
  localparam logic [7:0]  COOL_C         = 8'h96;

  // Slew accumulator increments, in ratio of the two slew references.
  localparam logic [4:0]  SLEW_INC_GND   = 5'h19;
  localparam logic [4:0]  SLEW_INC_REF   = 5'h09;

  // Undervoltage persistence time, rounded up to whole cycles.
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned UV_TIME_NS     = 80000;
  localparam int unsigned UV_CYCLES      = (UV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map, byte addresses.
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] STATUS_OFS     = 12'h004;
  localparam logic [11:0] TARGET_OFS     = 12'h008;
  localparam logic [11:0] FAULT_OFS      = 12'h00C;
  localparam logic [15:0] SLEW_PERIOD_RST = 16'h0008;

  // Status register fields.
  localparam int unsigned ST_STATE_LSB   = 0;
  localparam int unsigned ST_RAMP_BIT    = 8;
  localparam int unsigned ST_PG_BIT      = 9;
  localparam int unsigned ST_ALERT_BIT   = 10;
  localparam int unsigned ST_OVPEN_BIT   = 11;
  localparam int unsigned ST_DISCH_BIT   = 12;
  localparam int unsigned ST_PGPIN_BIT   = 13;
  localparam int unsigned ST_ALPIN_BIT   = 14;

  // Fault cause bits.
  localparam int unsigned FLT_OVP        = 0;
  localparam int unsigned FLT_UVP        = 1;
  localparam int unsigned FLT_FIXED      = 2;
  localparam int unsigned FLT_THERM      = 3;

  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_RUN     = 5'h02,
    ST_STOP    = 5'h04,
    ST_LATCH   = 5'h08,
    ST_CROWBAR = 5'h10
  } seq_state_t;

endpackage : buck_seq_pkg

/* testbench/host_model.sv */
`timescale 1ns/100ps
// Host side: presents the code and enable on the clock edge.
module host_model (
  input  wire logic       pclk,
  input  wire logic       want_on,
  input  wire logic [4:0] want_code,
  output logic            enable,
  output logic [4:0]      voltage_code
);
  initial enable = 1'b0;
  initial voltage_code = 5'h00;
  // Code is valid no later than the edge that raises enable.
  always @(posedge pclk)
  begin
    voltage_code <= want_code;
    enable       <= want_on;
  end
endmodule : host_model

/* testbench/buck_fault_sequencer_tb.sv */
`timescale 1ns/100ps
module buck_fault_sequencer_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, fb = 12'h000, thr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, enable, on = 0, pg_oe, al_oe, disch;
  logic [4:0]  code = 5'h00, vcode;
  logic [1:0]  hs, ls;
  logic [11:0] dac;
  logic        bias_ok = 1, slew = 0;
  logic [7:0]  temp = 8'h19;
  int          n_errors = 0, n_tests = 0;

  // Clock at 25 ns.
  initial forever #12.5 pclk = ~pclk;

  host_model host (.pclk(pclk), .want_on(on), .want_code(code), .enable(enable),
    .voltage_code(vcode));

  buck_fault_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .enable(enable), .voltage_code(vcode), .filtered_bias_supply_ok(bias_ok),
    .slew_set_pin(slew), .output_feedback(fb), .thermistor_sense(thr), .die_temp(temp),
    .on_pulse_req(2'b00), .over_current(2'b00), .sink_over_current(2'b00),
    .switch_node_sense(2'b00), .low_side_sense(2'b00), .high_side_gate_drive(hs),
    .low_side_gate_drive(ls), .dac_target_voltage(dac), .feedback_discharge(disch),
    .power_good_in(~pg_oe), .power_good_out(), .power_good_oe(pg_oe),
    .thermal_alert_in(~al_oe), .thermal_alert_out(), .thermal_alert_oe(al_oe));

  // Compares one result and counts it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // Waits, bounded, for the ramped target to reach a value.
  task wait_t(input logic [11:0] v);
    for (int i = 0; i < 3000 && dac !== v; i++) @(posedge pclk);
    chk(dac, v);
  endtask : wait_t

  // Control register reset value, unmapped access and fast slew setup.
  task t_regs;
    apb(0, buck_seq_pkg::CTRL_OFS, 0);
    chk(q, 32'h8);
    apb(0, 12'h010, 0);
    chk({q[30:0], e}, 32'h1);
    apb(1, buck_seq_pkg::CTRL_OFS, 32'h1);
    apb(0, buck_seq_pkg::CTRL_OFS, 0);
    chk(q, 32'h1);
    $display("test regs done");
  endtask : t_regs

  // Start at code all-ones, change code, window and thermal alert.
  task t_start;
    code <= 5'h1F; on <= 1;
    wait_t(12'h190);
    code <= 5'h1E;
    wait_t(12'h1F4);
    fb <= 12'h1F4;
    repeat (4) @(posedge pclk);
    chk(pg_oe, 0);
    fb <= 12'h1C1;
    repeat (4) @(posedge pclk);
    chk(pg_oe, 0);
    thr <= 12'h2D0;
    repeat (4) @(posedge pclk);
    chk({al_oe, pg_oe}, 2'b10);
    thr <= 12'h000; fb <= 12'h1F4;
    $display("test start done");
  endtask : t_start

  // Overvoltage: drop good, soft stop to 300 mV, latch, then enable cycle.
  task t_ovp;
    fb <= 12'h2BD;
    repeat (3) @(posedge pclk);
    chk(pg_oe, 1);
    wait_t(12'h12C);
    repeat (4) @(posedge pclk);
    chk({hs, ls, disch}, 5'h01);
    apb(0, buck_seq_pkg::STATUS_OFS, 0);
    chk(q[4:0], 5'h08);
    apb(0, buck_seq_pkg::FAULT_OFS, 0);
    chk(q[3:0], 4'h1);
    fb <= 12'h000; on <= 0;
    repeat (4) @(posedge pclk);
    on <= 1;
    repeat (4) @(posedge pclk);
    apb(0, buck_seq_pkg::STATUS_OFS, 0);
    chk(q[4:0], 5'h02);
    $display("test ovp done");
  endtask : t_ovp

  // Fixed overvoltage forces low-side gates high and good low.
  task t_fixed;
    fb <= 12'h708;
    repeat (4) @(posedge pclk);
    chk({ls, pg_oe}, 3'b111);
    apb(0, buck_seq_pkg::STATUS_OFS, 0);
    chk(q[4:0], 5'h10);
    $display("test fixed done");
  endtask : t_fixed

  // Bias loss clears all; slow slew with trip off; thermal shutdown and restart.
  task t_bias;
    fb <= 12'h000; bias_ok <= 0;
    repeat (3) @(posedge pclk);
    apb(0, buck_seq_pkg::STATUS_OFS, 0);
    chk(q[4:0], 5'h01);
    apb(0, buck_seq_pkg::FAULT_OFS, 0);
    chk(q[3:0], 4'h0);
    bias_ok <= 1; slew <= 1;
    wait_t(12'h1F4);
    fb <= 12'h2BD;
    repeat (3) @(posedge pclk);
    chk(pg_oe, 1);
    apb(0, buck_seq_pkg::STATUS_OFS, 0);
    chk(q[4:0], 5'h02);
    temp <= 8'hA0;
    repeat (3) @(posedge pclk);
    apb(0, buck_seq_pkg::STATUS_OFS, 0);
    chk(q[4:0], 5'h08);
    temp <= 8'h19; fb <= 12'h000; on <= 0;
    repeat (4) @(posedge pclk);
    on <= 1;
    repeat (4) @(posedge pclk);
    apb(0, buck_seq_pkg::STATUS_OFS, 0);
    chk(q[4:0], 5'h02);
    $display("test bias done");
  endtask : t_bias

  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_start;
    t_ovp;
    t_fixed;
    t_bias;
    test_done;
  end

  // Watchdog against a hang.
  initial
  begin
    #(25 * 20000);
    n_errors++;
    test_done;
  end
endmodule : buck_fault_sequencer_tb
